// file: logic/hrs_pkg.sv
// Constants and types for the hub reset and configuration sequencer
package hrs_pkg;

    localparam int CLK_NS       = 20;
    localparam int T_OPER_NS    = 500_000;
    localparam int T_DRIVE_NS   = 1_500;
    localparam int T_EE_MAX_US  = 99_500;
    localparam int T_SMB_MAX_US = 300_000;

    // Least time rounds up, longest time rounds down
    localparam int OPER_CYC  = (T_OPER_NS + CLK_NS - 1) / CLK_NS;
    localparam int DRIVE_CYC = T_DRIVE_NS / CLK_NS;
    localparam int EE_CYC    = (T_EE_MAX_US * 1000) / CLK_NS;
    localparam int SMB_CYC   = (T_SMB_MAX_US / CLK_NS) * 1000;

    localparam int TMR_W     = 24;
    localparam int WAKE_CYC  = 2;
    localparam int N_PORT    = 3;
    localparam int N_LED     = 3;
    localparam int ADDR_W    = 7;

    localparam logic [1:0] MODE_DEF = 2'h0;
    localparam logic [1:0] MODE_EE  = 2'h1;

    localparam logic [7:0] CFG_DEFAULT = 8'h00;
    localparam int         CFG_STRAP_LSB = 0;

    typedef enum logic [7:0] {
        ST_WAKE   = 8'h01,
        ST_SAMPLE = 8'h02,
        ST_DRIVE  = 8'h04,
        ST_STAB   = 8'h08,
        ST_EEPROM = 8'h10,
        ST_SMBUS  = 8'h20,
        ST_ATTACH = 8'h40,
        ST_RUN    = 8'h80
    } hrs_state_t;

endpackage

// file: logic/hrs_seq.sv
// Hub reset, strap sampling, configuration load and attach sequencer
`timescale 1ns/1ps
`default_nettype none
module hrs_seq #(
    parameter int OPER_CYC = hrs_pkg::OPER_CYC,
    parameter int EE_CYC   = hrs_pkg::EE_CYC,
    parameter int SMB_CYC  = hrs_pkg::SMB_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    input  wire logic [2:0]  led_pad_i,
    input  wire logic [1:0]  cfg_mode_i,
    input  wire logic        self_powered_i,
    input  wire logic        ee_done_i,
    input  wire logic        smbus_attach_i,
    input  wire logic        bus_reset_i,
    input  wire logic        addr_wr_i,
    input  wire logic [6:0]  addr_i,
    input  wire logic        set_config_i,
    input  wire logic        suspend_i,
    input  wire logic        resume_i,
    input  wire logic [2:0]  port_power_req_i,
    input  wire logic [2:0]  led_on_i,
    output logic [2:0]       led_out_o,
    output logic [2:0]       led_oe_o,
    output logic [2:0]       port_power_enable_o,
    output logic             port_enable_o,
    output logic             phy_enable_o,
    output logic             osc_run_o,
    output logic             pll_run_o,
    output logic             outputs_driven_o,
    output logic             operational_o,
    output logic             ee_start_o,
    output logic             ee_timeout_o,
    output logic             smbus_late_o,
    output logic             cfg_write_protect_o,
    output logic             usb_attach_o,
    output logic [7:0]       cfg_word_o,
    output logic [2:0]       strap_o,
    output logic [6:0]       usb_addr_o,
    output logic             configured_o,
    output logic             suspended_o,
    output logic             tt_clear_o
);

    // ********************************************************
    // Pin synchronisers and timers
    // ********************************************************
    logic [5:0] sync_w;
    logic [2:0] strap_s;
    logic [1:0] mode_s;
    logic       selfp_s;

    hrs_sync #(
        .W (6)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .d_i     ({self_powered_i, cfg_mode_i, led_pad_i}),
        .q_o     (sync_w)
    );

    assign strap_s = sync_w[2:0];
    assign mode_s  = sync_w[4:3];
    assign selfp_s = sync_w[5];

    localparam int TW = hrs_pkg::TMR_W;

    hrs_pkg::hrs_state_t state_q;
    hrs_pkg::hrs_state_t state_d;

    logic          up_load;
    logic          up_done;
    logic          ph_load;
    logic [TW-1:0] ph_val;
    logic          ph_done;
    logic [1:0]    mode_q;
    logic          mode_is_def;
    logic          mode_is_ee;

    // Release-relative: wake and sample cycles already elapsed
    localparam int UP_LOAD = OPER_CYC - hrs_pkg::WAKE_CYC - 1;

    hrs_timer #(
        .W (TW)
    ) u_up (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .load_i  (up_load),
        .val_i   (TW'(UP_LOAD)),
        .done_o  (up_done)
    );

    hrs_timer #(
        .W (TW)
    ) u_ph (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .load_i  (ph_load),
        .val_i   (ph_val),
        .done_o  (ph_done)
    );

    // ********************************************************
    // Sequence state machine
    // ********************************************************
    logic [1:0] wake_cnt_q;
    logic       wake_end;
    logic       in_sample;
    logic       go_ee;
    logic       go_smb;
    logic       ee_end;
    logic       smb_end;

    assign mode_is_def = (mode_q == hrs_pkg::MODE_DEF);
    assign mode_is_ee  = (mode_q == hrs_pkg::MODE_EE);
    assign wake_end  = (wake_cnt_q == 2'(hrs_pkg::WAKE_CYC - 1));
    assign in_sample = (state_q == hrs_pkg::ST_SAMPLE);
    assign go_ee  = (state_q == hrs_pkg::ST_STAB) && up_done
                    && mode_is_ee;
    assign go_smb = (state_q == hrs_pkg::ST_STAB) && up_done
                    && !mode_is_ee && !mode_is_def;
    assign ee_end  = (state_q == hrs_pkg::ST_EEPROM)
                     && (ee_done_i || ph_done);
    assign smb_end = (state_q == hrs_pkg::ST_SMBUS) && smbus_attach_i;

    assign up_load = in_sample;
    assign ph_load = in_sample || go_ee || go_smb;
    assign ph_val  = in_sample ? TW'(hrs_pkg::DRIVE_CYC)
                   : go_ee     ? TW'(EE_CYC)
                   :             TW'(SMB_CYC);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            hrs_pkg::ST_WAKE: begin
                if (wake_end) begin
                    state_d = hrs_pkg::ST_SAMPLE;
                end
            end
            hrs_pkg::ST_SAMPLE: begin
                state_d = hrs_pkg::ST_DRIVE;
            end
            hrs_pkg::ST_DRIVE: begin
                if (ph_done) begin
                    state_d = hrs_pkg::ST_STAB;
                end
            end
            hrs_pkg::ST_STAB: begin
                if (up_done) begin
                    if (mode_is_def) begin
                        state_d = hrs_pkg::ST_ATTACH;
                    end else if (mode_is_ee) begin
                        state_d = hrs_pkg::ST_EEPROM;
                    end else begin
                        state_d = hrs_pkg::ST_SMBUS;
                    end
                end
            end
            hrs_pkg::ST_EEPROM: begin
                if (ee_end) begin
                    state_d = hrs_pkg::ST_ATTACH;
                end
            end
            hrs_pkg::ST_SMBUS: begin
                // No time limit: only the attach bit ends the load
                if (smb_end) begin
                    state_d = hrs_pkg::ST_ATTACH;
                end
            end
            hrs_pkg::ST_ATTACH: begin
                state_d = hrs_pkg::ST_RUN;
            end
            hrs_pkg::ST_RUN: begin
                state_d = hrs_pkg::ST_RUN;
            end
            default: begin
                state_d = hrs_pkg::ST_WAKE;
            end
        endcase
    end

    // Async reset forces every flop to its default and drops work
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q    <= hrs_pkg::ST_WAKE;
            wake_cnt_q <= 2'h0;
        end else if (ce_i) begin
            state_q <= state_d;
            if (!wake_end) begin
                wake_cnt_q <= wake_cnt_q + 2'h1;
            end
        end
    end

    // ********************************************************
    // Strap capture and default configuration
    // ********************************************************
    logic [2:0] strap_q;
    logic [7:0] cfg_word_q;
    logic [7:0] cfg_word_d;

    // Straps only steer configuration in default mode; decoded from the
    // pins because mode_q is only loaded on the sampling edge itself
    assign cfg_word_d = (mode_s == hrs_pkg::MODE_DEF)
        ? (hrs_pkg::CFG_DEFAULT
           | (8'(strap_s) << hrs_pkg::CFG_STRAP_LSB))
        : hrs_pkg::CFG_DEFAULT;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_q    <= 3'h0;
            mode_q     <= 2'h0;
            cfg_word_q <= hrs_pkg::CFG_DEFAULT;
        end else if (ce_i && in_sample) begin
            // Latched once; pads turn into LED drivers afterwards
            strap_q    <= strap_s;
            mode_q     <= mode_s;
            // Same decode as the sampled mode, taken in one edge
            cfg_word_q <= cfg_word_d;
        end
    end

    // ********************************************************
    // Start-up flags
    // ********************************************************
    logic run_q;
    logic drive_q;
    logic ee_start_q;
    logic ee_to_q;
    logic smb_late_q;
    logic wp_q;
    logic attach_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_q      <= 1'b0;
            drive_q    <= 1'b0;
            ee_start_q <= 1'b0;
            ee_to_q    <= 1'b0;
            smb_late_q <= 1'b0;
            wp_q       <= 1'b0;
            attach_q   <= 1'b0;
        end else if (ce_i) begin
            run_q      <= 1'b1;
            ee_start_q <= go_ee;
            if (state_q == hrs_pkg::ST_DRIVE && ph_done) begin
                drive_q <= 1'b1;
            end
            if (ee_end && !ee_done_i) begin
                ee_to_q <= 1'b1;
            end
            // Bus-powered boards only: late load is reported, not cut
            if (state_q == hrs_pkg::ST_SMBUS && ph_done
                && !selfp_s) begin
                smb_late_q <= 1'b1;
            end
            if (smb_end) begin
                wp_q <= 1'b1;
            end
            if (state_q == hrs_pkg::ST_ATTACH) begin
                attach_q <= 1'b1;
            end
        end
    end

    // ********************************************************
    // USB device state and downstream power
    // ********************************************************
    logic [6:0] addr_q;
    logic       conf_q;
    logic       susp_q;
    logic       tt_clr_q;
    logic [2:0] ppe_q;
    logic [2:0] led_out_q;
    logic       running;

    assign running = (state_q == hrs_pkg::ST_RUN);

    // Bus reset clears the hub's address, configuration and suspend, and drops power on every port
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_q   <= 7'h00;
            conf_q   <= 1'b0;
            susp_q   <= 1'b0;
            tt_clr_q <= 1'b0;
            ppe_q    <= 3'h0;
        end else if (ce_i) begin
            tt_clr_q <= bus_reset_i;
            if (bus_reset_i) begin
                addr_q <= 7'h00;
                conf_q <= 1'b0;
                susp_q <= 1'b0;
                ppe_q  <= 3'h0;
            end else begin
                if (addr_wr_i) begin
                    addr_q <= addr_i;
                end
                if (set_config_i) begin
                    conf_q <= 1'b1;
                end
                if (suspend_i) begin
                    susp_q <= 1'b1;
                end else if (resume_i) begin
                    susp_q <= 1'b0;
                end
                ppe_q <= (running && conf_q)
                         ? port_power_req_i : 3'h0;
            end
        end
    end

    // Polarity chosen by the strap seen on the same pad
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_out_q <= 3'h0;
        end else if (ce_i) begin
            led_out_q <= led_on_i ^ strap_q;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign led_out_o           = led_out_q;
    assign led_oe_o            = {3{drive_q}};
    assign port_power_enable_o = ppe_q;
    assign port_enable_o       = running;
    assign phy_enable_o        = run_q;
    assign osc_run_o           = run_q;
    assign pll_run_o           = run_q;
    assign outputs_driven_o    = drive_q;
    assign operational_o       = up_done;
    assign ee_start_o          = ee_start_q;
    assign ee_timeout_o        = ee_to_q;
    assign smbus_late_o        = smb_late_q;
    assign cfg_write_protect_o = wp_q;
    assign usb_attach_o        = attach_q;
    assign cfg_word_o          = cfg_word_q;
    assign strap_o             = strap_q;
    assign usb_addr_o          = addr_q;
    assign configured_o        = conf_q;
    assign suspended_o         = susp_q;
    assign tt_clear_o          = tt_clr_q;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_ports_off;
        !running |=> port_power_enable_o == 3'h0;
    endproperty
    a_ports_off: assert property (p_ports_off)
        else $error("port power on before hub runs");

    property p_bus_rst_pwr;
        ce_i && bus_reset_i |=> port_power_enable_o == 3'h0
                                && tt_clear_o;
    endproperty
    a_bus_rst_pwr: assert property (p_bus_rst_pwr)
        else $error("bus reset left port power or buffers");

    property p_bus_rst_addr;
        ce_i && bus_reset_i |=> usb_addr_o == 7'h00
                                && !configured_o;
    endproperty
    a_bus_rst_addr: assert property (p_bus_rst_addr)
        else $error("bus reset kept address or config");

    property p_bus_rst_wake;
        ce_i && bus_reset_i && suspended_o |=> !suspended_o;
    endproperty
    a_bus_rst_wake: assert property (p_bus_rst_wake)
        else $error("bus reset left hub suspended");

    property p_strap_hold;
        !in_sample |=> $stable(strap_o);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap value changed after capture");

    property p_led_pol;
        ce_i |=> led_out_o == ($past(led_on_i) ^ $past(strap_o));
    endproperty
    a_led_pol: assert property (p_led_pol)
        else $error("led polarity does not follow strap");

    property p_smb_wait;
        state_q == hrs_pkg::ST_SMBUS && !smbus_attach_i
            |=> !usb_attach_o;
    endproperty
    a_smb_wait: assert property (p_smb_wait)
        else $error("attach before smbus load ended");

    property p_smb_attach;
        ce_i && smb_end ##1 ce_i[*2]
            |-> cfg_write_protect_o && usb_attach_o;
    endproperty
    a_smb_attach: assert property (p_smb_attach)
        else $error("no attach or protect after load");

    property p_ee_start;
        ee_start_o |-> operational_o && mode_is_ee;
    endproperty
    a_ee_start: assert property (p_ee_start)
        else $error("eeprom read started too early");

    property p_drive_time;
        ce_i && in_sample ##1 ce_i[*8] |-> !outputs_driven_o;
    endproperty
    a_drive_time: assert property (p_drive_time)
        else $error("outputs driven too soon after sampling");

endmodule
`default_nettype wire

// file: logic/hrs_sync.sv
// Two-stage synchroniser for pins entering the clock domain
`timescale 1ns/1ps
`default_nettype none
module hrs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

// file: logic/hrs_timer.sv
// Loadable down-counter that flags expiry of a phase
`timescale 1ns/1ps
`default_nettype none
module hrs_timer #(
    parameter int W = 24
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] val_i,
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic         armed_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q   <= '0;
            armed_q <= 1'b0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_q   <= val_i;
                armed_q <= 1'b1;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    // Level: stays high from expiry until the next load
    assign done_o = armed_q && (cnt_q == '0) && !load_i;
endmodule
`default_nettype wire

// file: verif/hrs_far_model.sv
// Far-side model: configuration source (EEPROM loader and SMBus host)
`timescale 1ns/1ps
`default_nettype none
module hrs_far_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ee_start_i,
    input  wire logic        operational_i,
    input  wire logic        smb_sel_i,
    input  wire logic        mute_i,
    input  wire logic [15:0] dly_i,
    output logic             ee_done_o,
    output logic             smbus_attach_o
);
    logic [15:0] ee_cnt_q;
    logic [15:0] smb_cnt_q;
    logic        busy_q;

    // Mute models a missing or dead EEPROM that never finishes
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_q    <= 1'b0;
            ee_cnt_q  <= 16'h0000;
            ee_done_o <= 1'b0;
        end else begin
            ee_done_o <= 1'b0;
            if (ee_start_i && !mute_i) begin
                busy_q   <= 1'b1;
                ee_cnt_q <= 16'h0000;
            end else if (busy_q) begin
                ee_cnt_q <= ee_cnt_q + 16'h0001;
                if (ee_cnt_q == dly_i) begin
                    busy_q    <= 1'b0;
                    ee_done_o <= 1'b1;
                end
            end
        end
    end

    // Code load runs from operational; the attach bit ends it and stays set
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            smb_cnt_q      <= 16'h0000;
            smbus_attach_o <= 1'b0;
        end else if (smb_sel_i && operational_i && !smbus_attach_o) begin
            smb_cnt_q <= smb_cnt_q + 16'h0001;
            if (smb_cnt_q == dly_i) begin
                smbus_attach_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the hub reset and configuration sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int OPER = 40;
    localparam int EEC  = 50;
    localparam int SMBC = 30;
    typedef struct {string nm; int sel; logic [31:0] exp;} hrs_note_t;
    hrs_note_t q[$];
    logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
    logic [2:0] led_pad_i = 3'h0, port_power_req_i = 3'h0, led_on_i = 3'h0;
    logic [1:0] cfg_mode_i = 2'h0;
    logic [6:0] addr_i = 7'h00;
    logic self_powered_i = 1'b0, bus_reset_i = 1'b0, addr_wr_i = 1'b0;
    logic set_config_i = 1'b0, suspend_i = 1'b0, resume_i = 1'b0;
    logic mute = 1'b0;
    logic [15:0] dly = 16'h000a;
    logic ee_done, smb_att;
    logic [2:0] led_out_o, led_oe_o, port_power_enable_o, strap_o;
    logic port_enable_o, phy_enable_o, osc_run_o, pll_run_o;
    logic outputs_driven_o, operational_o, ee_start_o, ee_timeout_o;
    logic smbus_late_o, cfg_write_protect_o, usb_attach_o;
    logic configured_o, suspended_o, tt_clear_o;
    logic [7:0] cfg_word_o, rnd = 8'h5d;
    logic [6:0] usb_addr_o;
    logic [2:0] pads;
    int error_cnt = 0, n_checks = 0, n;

    always #10 clk_i = ~clk_i;

    hrs_seq #(.OPER_CYC(OPER), .EE_CYC(EEC), .SMB_CYC(SMBC)) hrs_seq_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .led_pad_i(led_pad_i), .cfg_mode_i(cfg_mode_i),
        .self_powered_i(self_powered_i), .ee_done_i(ee_done),
        .smbus_attach_i(smb_att), .bus_reset_i(bus_reset_i),
        .addr_wr_i(addr_wr_i), .addr_i(addr_i), .set_config_i(set_config_i),
        .suspend_i(suspend_i), .resume_i(resume_i),
        .port_power_req_i(port_power_req_i), .led_on_i(led_on_i),
        .led_out_o(led_out_o), .led_oe_o(led_oe_o),
        .port_power_enable_o(port_power_enable_o),
        .port_enable_o(port_enable_o), .phy_enable_o(phy_enable_o),
        .osc_run_o(osc_run_o), .pll_run_o(pll_run_o),
        .outputs_driven_o(outputs_driven_o), .operational_o(operational_o),
        .ee_start_o(ee_start_o), .ee_timeout_o(ee_timeout_o),
        .smbus_late_o(smbus_late_o),
        .cfg_write_protect_o(cfg_write_protect_o),
        .usb_attach_o(usb_attach_o), .cfg_word_o(cfg_word_o),
        .strap_o(strap_o), .usb_addr_o(usb_addr_o),
        .configured_o(configured_o), .suspended_o(suspended_o),
        .tt_clear_o(tt_clear_o));

    hrs_far_model hrs_far_model_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ee_start_i(ee_start_o),
        .operational_i(operational_o), .smb_sel_i(cfg_mode_i[1]),
        .mute_i(mute), .dly_i(dly), .ee_done_o(ee_done),
        .smbus_attach_o(smb_att));

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic [31:0] obs(input int sel);
        case (sel)
            0: return {29'h0, strap_o};
            1: return {24'h0, cfg_word_o};
            2: return {29'h0, led_out_o};
            3: return {29'h0, led_oe_o};
            4: return {29'h0, port_power_enable_o};
            5: return {31'h0, port_enable_o};
            6: return {29'h0, phy_enable_o, osc_run_o, pll_run_o};
            7: return {31'h0, outputs_driven_o};
            8: return {31'h0, operational_o};
            9: return {31'h0, usb_attach_o};
            10: return {31'h0, ee_timeout_o};
            11: return {31'h0, smbus_late_o};
            12: return {31'h0, cfg_write_protect_o};
            13: return {25'h0, usb_addr_o};
            14: return {31'h0, configured_o};
            15: return {31'h0, suspended_o};
            16: return {31'h0, tt_clear_o};
            default: return {31'h0, ee_start_o};
        endcase
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic note(string nm, int sel, logic [31:0] exp);
        hrs_note_t e;
        e.nm = nm;
        e.sel = sel;
        e.exp = exp;
        q.push_back(e);
    endtask

    // Monitor: settled outputs are compared against the oldest notes
    always @(negedge clk_i) begin
        while (q.size() > 0) begin
            chk(q[0].nm, obs(q[0].sel), q[0].exp);
            void'(q.pop_front());
        end
    end

    task automatic end_sim();
        repeat (2) @(posedge clk_i);
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Bounded wait for an output bit; exhausting the bound ends the run
    task automatic wt(int sel, int lim);
        n = 0;
        while (obs(sel)[0] !== 1'b1) begin
            if (n >= lim) begin
                $display("ERROR wait sel %0d expected 1 seen timeout", sel);
                error_cnt++;
                end_sim();
            end
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask

    // One-cycle request: 0 address, 1 config, 2 suspend, else bus reset
    task automatic pulse(int sel);
        @(posedge clk_i);
        case (sel)
            0: addr_wr_i <= 1'b1;
            1: set_config_i <= 1'b1;
            2: suspend_i <= 1'b1;
            default: bus_reset_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {addr_wr_i, set_config_i, suspend_i, bus_reset_i} <= 4'h0;
        #1;
    endtask

    // Hardware reset, held 1 us; pins set up before release
    task automatic hw_reset(logic [1:0] mode, logic sp);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        rnd = lfsr(rnd);
        pads = rnd[2:0];
        led_pad_i <= pads;
        cfg_mode_i <= mode;
        self_powered_i <= sp;
        repeat (50) @(posedge clk_i);
        #1;
        note("port_power", 4, 0);
        note("port_enable", 5, 0);
        note("phy_osc_pll", 6, 0);
        note("led_oe", 3, 0);
        note("cfg_word", 1, 0);
        note("attach", 9, 0);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        // Default/strap mode
        hw_reset(2'h0, 1'b0);
        wt(8, OPER + 5);
        note("oper_delay", 8, {31'h0, n >= OPER - 2});
        wt(7, 110);
        note("drive_delay", 7, {31'h0, n <= 103 - OPER});
        wt(9, 20);
        note("strap", 0, pads);
        note("cfg_word", 1, {5'h00, pads});
        note("led_oe", 3, 3'h7);
        rnd = lfsr(rnd);
        @(posedge clk_i);
        led_on_i <= rnd[2:0];
        led_pad_i <= ~pads;
        repeat (3) @(posedge clk_i);
        #1;
        note("led_out", 2, rnd[2:0] ^ pads);
        note("strap_hold", 0, pads);
        // Address, configuration, power, suspend, then upstream bus reset
        rnd = lfsr(rnd);
        addr_i <= rnd[6:0] | 7'h01;
        port_power_req_i <= rnd[7:5] | 3'h1;
        pulse(0);
        pulse(1);
        @(posedge clk_i);
        #1;
        note("addr", 13, rnd[6:0] | 7'h01);
        note("port_power", 4, rnd[7:5] | 3'h1);
        pulse(2);
        note("suspended", 15, 1);
        pulse(3);
        note("addr", 13, 0);
        note("configured", 14, 0);
        note("port_power", 4, 0);
        note("tt_clear", 16, 1);
        note("suspended", 15, 0);
        note("port_enable", 5, 1);
        note("strap", 0, pads);
        // EEPROM mode, prompt loader
        hw_reset(2'h1, 1'b0);
        wt(17, 100);
        note("operational", 8, 1);
        wt(9, 30);
        note("ee_timeout", 10, 0);
        // EEPROM mode, silent loader runs into the timeout
        mute <= 1'b1;
        hw_reset(2'h1, 1'b0);
        wt(9, 150);
        note("ee_limit", 10, {31'h0, n >= OPER + EEC});
        note("ee_timeout", 10, 1);
        mute <= 1'b0;
        // SMBus, self-powered, load slower than the bus-powered limit
        dly <= 16'h0050;
        hw_reset(2'h2, 1'b1);
        wt(12, OPER + 120);
        note("smb_wait", 12, {31'h0, n >= OPER + 80});
        note("smb_late", 11, 0);
        wt(9, 5);
        note("attach", 9, 1);
        // SMBus, bus-powered, late load is reported
        hw_reset(2'h3, 1'b0);
        wt(9, OPER + 120);
        note("smb_late", 11, 1);
        note("protect", 12, 1);
        end_sim();
    end
endmodule
`default_nettype wire
